// ==== logic/tmr_pkg.sv ====
// package: register map, field layout and bus carrier types of the 16-bit timer/counter
`default_nettype none
package tmr_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_COUNT_LOW  = 8'h00;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFS_CONTROL    = 8'h08;
    localparam logic [7:0] OFS_STATUS     = 8'h0C;

    // ****************************************
    // counter_control fields
    // ****************************************
    localparam int CTL_WIDE      = 7;
    localparam int CTL_TBS_HI    = 6;
    localparam int CTL_PS_HI     = 5;
    localparam int CTL_PS_LO     = 4;
    localparam int CTL_TBS_LO    = 3;
    localparam int CTL_SYNC_OFF  = 2;
    localparam int CTL_CLK_SRC   = 1;
    localparam int CTL_RUN       = 0;

    // ****************************************
    // status register fields
    // ****************************************
    localparam int STS_OVF_FLAG  = 0;
    localparam int STS_OVF_IE    = 1;
    localparam int STS_AUX_OSC   = 2;

    // ****************************************
    // reset values and constants
    // ****************************************
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONE = 16'hFFFF;
    localparam logic [3:0]  MODE_SPECIAL  = 4'hB;
    localparam int          INSTR_DIV     = 4;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_type;

    typedef struct packed {
        logic [3:0] mode;
        logic       match;
    } cmp_trig_type;
endpackage
`default_nettype wire

// ==== logic/timer_counter.sv ====
// 16-bit timer/counter with prescaler, buffered wide access and compare trigger reset
// Contract
// RULE1: clock select zero counts one step per instruction cycle, a quarter of clock.
// RULE2: clock select one counts rising edges of external input or aux oscillator.
// RULE3: aux oscillator enabled forces both pins to inputs, port reads give zero.
// RULE4: wide access on makes high-byte address select the buffer register.
// RULE5: in wide mode each low-byte read copies live high byte into buffer.
// RULE6: in wide mode a low-byte write loads high byte from buffer together.
// RULE7: in wide mode the live high byte is reached only via the buffer.
// RULE8: high-byte write keeps the prescaler; low-byte write clears it.
// RULE9: aux oscillator is the source only when its enable and clock select set.
// RULE10: counter counts up from zero to all ones, wraps to zero as overflow.
// RULE11: overflow latches the flag; interrupt raised only when enable bit set.
// RULE12: assigned compare unit in special trigger mode resets counter on trigger.
// RULE13: the same trigger starts an analog conversion if converter is enabled.
// RULE14: software uses timer or synchronous counter mode for trigger resets.
// RULE15: compare value pair then acts as period, count runs zero to it.
// RULE16: software count write in same cycle as trigger wins, reset discarded.
// RULE17: trigger from second compare unit never sets the overflow flag.
// RULE18: prescale codes 00,01,10,11 divide source by 1,2,4,8.
// RULE19: external mode syncs input unless sync-off set; ignored in internal mode.
// RULE20: select 1x gives counter to both units, 01 second only, 00 none.
// RULE21: counter advances only while run bit set, otherwise holds its value.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module timer_counter
    import tmr_pkg::*;
#(
    parameter int unsigned CLK_PER_INSTR = INSTR_DIV
) (
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire wb_req_type   wb_req,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         ext_count_input,
    input  wire logic         aux_osc_in,
    input  wire cmp_trig_type cmp_unit1,
    input  wire cmp_trig_type cmp_unit2,
    input  wire logic         adc_enabled,
    input  wire logic [1:0]   port_direction,
    input  wire logic [1:0]   pin_level,
    output logic [1:0]        pin_dir_eff,
    output logic [1:0]        pin_read,
    output logic              adc_start,
    output logic              overflow_irq,
    output logic              unit1_uses_this,
    output logic              unit2_uses_this
);
    // an instruction cycle of zero clocks cannot be counted
    if (CLK_PER_INSTR < 1) begin : g_div_check
        $error("CLK_PER_INSTR must be at least 1");
    end

    // one divider bit is kept even when every clock is an instruction cycle
    localparam int DIV_W = (CLK_PER_INSTR > 1) ? $clog2(CLK_PER_INSTR) : 1;

    // ****************************************
    // state
    // ****************************************
    logic [15:0]      count;
    logic [7:0]       high_buf;
    logic [7:0]       control;
    logic             overflow_flag;
    logic             overflow_irq_enable;
    logic             aux_osc_enable;
    logic [2:0]       pre;
    logic [DIV_W-1:0] div;
    logic             sync1;
    logic             sync2;
    logic             sync3;
    logic             raw_q;
    logic             ack;
    logic [31:0]      rdata;

    // ****************************************
    // bus decode
    // ****************************************
    wire acc      = wb_req.cyc & wb_req.stb & ~ack;
    wire wr_ok    = acc & wb_req.we & wb_req.sel[0];
    wire rd_ok    = acc & ~wb_req.we;
    wire [7:0] wd = wb_req.dat[7:0];
    wire hit_low  = wb_req.adr == OFS_COUNT_LOW;
    wire hit_high = wb_req.adr == OFS_COUNT_HIGH;
    wire hit_ctl  = wb_req.adr == OFS_CONTROL;
    wire hit_sts  = wb_req.adr == OFS_STATUS;
    wire wide     = control[CTL_WIDE];
    wire wr_low   = wr_ok & hit_low;
    wire wr_high  = wr_ok & hit_high;
    wire rd_low   = rd_ok & hit_low;

    // ****************************************
    // count source
    // ****************************************
    wire clk_src  = control[CTL_CLK_SRC];
    wire sync_off = control[CTL_SYNC_OFF];
    wire run      = control[CTL_RUN];
    wire [1:0] ps = control[CTL_PS_HI:CTL_PS_LO];
    wire ext_src  = (aux_osc_enable & clk_src) ? aux_osc_in : ext_count_input; // [RULE9]
    wire instr_tick = div == DIV_W'(CLK_PER_INSTR - 1);
    // sync path adds latency but is the only one safe for trigger resets
    wire edge_sync = sync2 & ~sync3;
    wire edge_raw  = ext_src & ~raw_q;
    wire ext_tick  = sync_off ? edge_raw : edge_sync; // [RULE19]
    wire src_tick  = clk_src ? ext_tick : instr_tick; // [RULE1] [RULE2]

    function automatic logic [2:0] ps_mask(input logic [1:0] code);
        ps_mask = 3'((4'h1 << code) - 4'h1);
    endfunction

    wire [2:0] mask = ps_mask(ps);
    wire pre_full   = (pre & mask) == mask; // [RULE18]
    wire adv        = run & src_tick & pre_full; // [RULE21]

    // ****************************************
    // compare trigger
    // ****************************************
    wire tbs_hi = control[CTL_TBS_HI];
    wire tbs_lo = control[CTL_TBS_LO];
    assign unit1_uses_this = tbs_hi; // [RULE20]
    assign unit2_uses_this = tbs_hi | tbs_lo; // [RULE20]

    function automatic logic special(input cmp_trig_type u);
        special = u.match & (u.mode == MODE_SPECIAL);
    endfunction

    // works in any mode, but an unsynchronised source may race the reset
    wire trig = (unit1_uses_this & special(cmp_unit1))
              | (unit2_uses_this & special(cmp_unit2)); // [RULE12] [RULE15]
    wire cnt_wr = wr_low | (wr_high & ~wide);

    // ****************************************
    // next count
    // ****************************************
    logic [15:0] next_count;
    always_comb begin
        next_count = count;
        if (wr_low) begin
            next_count = {wide ? high_buf : count[15:8], wd}; // [RULE6]
        end else if (wr_high & ~wide) begin
            next_count = {wd, count[7:0]}; // [RULE7]
        end else if (trig) begin
            next_count = COUNT_RESET; // [RULE12] [RULE16]
        end else if (adv) begin
            next_count = count + 16'h0001; // [RULE10]
        end
    end

    // trigger resets load zero directly, so only a true wrap sets the flag
    wire wrap = adv & ~cnt_wr & ~trig & (count == COUNT_ALL_ONE); // [RULE10] [RULE17]
    wire ovf_clr = wr_ok & hit_sts & wd[STS_OVF_FLAG];

    // ****************************************
    // read mux
    // ****************************************
    wire [7:0] high_view = wide ? high_buf : count[15:8]; // [RULE4] [RULE7]
    wire [7:0] sts_view  = {5'h00, aux_osc_enable, overflow_irq_enable, overflow_flag};
    wire [7:0] rd_byte   = hit_low  ? count[7:0] :
                           hit_high ? high_view :
                           hit_ctl  ? control :
                           hit_sts  ? sts_view : 8'h00;

    // ****************************************
    // bus response
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= acc;
        end
    end

    // read data holds until the next read, so a slow master still sees it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd_ok) begin
            rdata <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************
    // counter and high-byte buffer
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    // outside wide mode the buffer is idle and the high byte is live
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            high_buf <= 8'h00;
        end else if (rd_low & wide) begin
            high_buf <= count[15:8]; // [RULE5]
        end else if (wr_high & wide) begin
            high_buf <= wd; // [RULE4]
        end
    end

    // a control write leaves the prescaler alone; only a low-byte write restarts it
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            control <= CONTROL_RESET;
        end else if (wr_ok & hit_ctl) begin
            control <= wd;
        end
    end

    // ****************************************
    // status flags
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            overflow_flag <= 1'b0;
        end else begin
            // a wrap in the clearing cycle is kept
            overflow_flag <= wrap | (overflow_flag & ~ovf_clr); // [RULE11]
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            overflow_irq_enable <= 1'b0;
            aux_osc_enable      <= 1'b0;
        end else if (wr_ok & hit_sts) begin
            overflow_irq_enable <= wd[STS_OVF_IE];
            aux_osc_enable      <= wd[STS_AUX_OSC];
        end
    end

    // ****************************************
    // prescaler
    // ****************************************
    // ticks that arrive while stopped are dropped, not banked
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre <= 3'h0;
        end else if (wr_low) begin
            pre <= 3'h0; // [RULE8]
        end else if (run & src_tick) begin
            pre <= pre_full ? 3'h0 : pre + 3'h1; // [RULE18]
        end
    end

    // ****************************************
    // instruction divider
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            div <= '0;
        end else begin
            div <= instr_tick ? '0 : div + DIV_W'(1); // [RULE1]
        end
    end

    // ****************************************
    // external edge detection
    // ****************************************
    // only the last two stages feed the edge detector
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= ext_src;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_q <= 1'b0;
        end else begin
            raw_q <= ext_src;
        end
    end

    // ****************************************
    // conversion start
    // ****************************************
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adc_start <= 1'b0;
        end else begin
            adc_start <= trig & adc_enabled; // [RULE13]
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign wb_ack_o     = ack;
    assign wb_dat_o     = rdata;
    assign overflow_irq = overflow_flag & overflow_irq_enable; // [RULE11]
    assign pin_dir_eff  = aux_osc_enable ? 2'b11 : port_direction; // [RULE3]
    assign pin_read     = aux_osc_enable ? 2'b00 : pin_level; // [RULE3]
endmodule // timer_counter
`default_nettype wire

// ==== tb/tmr_sva.sv ====
// checker: port-level properties of the timer/counter
`timescale 1ns/1ps
`default_nettype none
module tmr_sva
    import tmr_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire wb_req_type   wb_req,
    input  wire logic [31:0]  wb_dat_o,
    input  wire logic         wb_ack_o,
    input  wire cmp_trig_type cmp_unit1,
    input  wire cmp_trig_type cmp_unit2,
    input  wire logic         adc_enabled,
    input  wire logic [1:0]   port_direction,
    input  wire logic [1:0]   pin_level,
    input  wire logic [1:0]   pin_dir_eff,
    input  wire logic [1:0]   pin_read,
    input  wire logic         adc_start,
    input  wire logic         unit1_uses_this,
    input  wire logic         unit2_uses_this
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire  trig = (cmp_unit1.match && cmp_unit1.mode == MODE_SPECIAL && unit1_uses_this)
              || (cmp_unit2.match && cmp_unit2.mode == MODE_SPECIAL && unit2_uses_this);
    logic trig_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) trig_q <= 1'b0;
        else trig_q <= trig && adc_enabled;
    end
    a_ack_next_cycle: assert property ((wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_pin_forced_in: assert property ((pin_dir_eff != port_direction) |->
        pin_dir_eff == 2'h3 && pin_read == 2'h0) else $error("pin direction override wrong");
    a_pin_read_zero: assert property ((pin_read != pin_level) |-> pin_read == 2'h0 && pin_dir_eff == 2'h3)
        else $error("pin read value wrong");
    a_adc_follows: assert property ((trig && adc_enabled) |=> adc_start)
        else $error("conversion start missing after trigger");
    a_adc_has_cause: assert property (adc_start |-> trig_q)
        else $error("conversion start without trigger");
    a_unit_share: assert property (unit1_uses_this |-> unit2_uses_this)
        else $error("time base assignment inconsistent");
    c_trig_adc: cover property (trig && adc_enabled);
    c_pin_forced: cover property (pin_dir_eff == 2'h3 && port_direction != 2'h3);
    c_unit1_assigned: cover property (unit1_uses_this && cmp_unit1.match);
endmodule // tmr_sva
bind timer_counter tmr_sva u_tmr_sva (.ref_clk, .arst_n, .wb_req, .wb_dat_o, .wb_ack_o, .cmp_unit1, .cmp_unit2,
    .adc_enabled, .port_direction, .pin_level, .pin_dir_eff, .pin_read, .adc_start, .unit1_uses_this,
    .unit2_uses_this);
`default_nettype wire

// ==== tb/src_model.sv ====
// partner model: external edge source, aux oscillator and compare triggers
`timescale 1ns/1ps
`default_nettype none
module src_model
    import tmr_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         ext_on,
    input  wire logic         fire1,
    input  wire logic         fire2,
    input  wire logic [3:0]   mode,
    output logic              ext_count_input,
    output logic              aux_osc_in,
    output var cmp_trig_type  cmp_unit1,
    output var cmp_trig_type  cmp_unit2
);
    logic [2:0] phase;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) phase <= 3'h0;
        else phase <= ext_on ? phase + 3'h1 : 3'h0;
    end
    // sources stand low while idle; periods 8 and 4 clocks
    assign ext_count_input = ext_on & phase[2];
    assign aux_osc_in      = ext_on & phase[1];
    // triggers only fired while counting is synchronous
    assign cmp_unit1 = '{mode, fire1};
    assign cmp_unit2 = '{mode, fire2};
endmodule // src_model
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: self-checking scenarios for the timer/counter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tmr_pkg::*;
    logic ref_clk, arst_n, ext_on, fire1, fire2, ext_in, aux_in, ack, irq, adc, adc_en, u1, u2;
    logic [3:0] mode;
    logic [31:0] rdat;
    logic [1:0] pdir, pread;
    wb_req_type req;
    cmp_trig_type cu1, cu2;
    int fail_count, check_count, adc_seen;
    timer_counter #(.CLK_PER_INSTR(2)) u_timer_counter (.ref_clk(ref_clk), .arst_n(arst_n), .wb_req(req),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_count_input(ext_in), .aux_osc_in(aux_in), .cmp_unit1(cu1),
        .cmp_unit2(cu2), .adc_enabled(adc_en), .port_direction(2'h1), .pin_level(2'h2), .pin_dir_eff(pdir),
        .pin_read(pread), .adc_start(adc), .overflow_irq(irq), .unit1_uses_this(u1), .unit2_uses_this(u2));
    src_model u_src_model (.ref_clk(ref_clk), .arst_n(arst_n), .ext_on(ext_on), .fire1(fire1), .fire2(fire2),
        .mode(mode), .ext_count_input(ext_in), .aux_osc_in(aux_in), .cmp_unit1(cu1), .cmp_unit2(cu2));
    // conversion starts seen at the pin, judged by the trigger scenario
    always @(posedge ref_clk) begin
        if (adc === 1'b1) adc_seen++;
    end
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h00_0000, d}};
        do begin @(posedge ref_clk); n++; end while (ack !== 1'b1 && n < 20);
        if (n >= 20) begin fail_count++; summarize(); end
        q = rdat[7:0];
        req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin $display("Error %s expected %h seen %h", s, e, g); fail_count++; end
    endtask
    task automatic rdchk(input string s, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(s, e, q);
    endtask
    // low-byte advance over exactly 64 clocks between two taken reads
    task automatic span(output logic [7:0] d);
        logic [7:0] a, b;
        bus(1'b0, OFS_COUNT_LOW, 8'h00, a);
        repeat (61) @(posedge ref_clk);
        bus(1'b0, OFS_COUNT_LOW, 8'h00, b);
        d = b - a;
    endtask
    task automatic pulse(input logic u);
        if (u) fire2 <= 1'b1; else fire1 <= 1'b1;
        @(posedge ref_clk);
        fire1 <= 1'b0;
        fire2 <= 1'b0;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        rdchk("control", OFS_CONTROL, 8'h00);
        rdchk("status", OFS_STATUS, 8'h00);
        rdchk("unmapped", 8'h10, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_rate();
        logic [7:0] d;
        for (int p = 0; p < 4; p++) begin
            wr(OFS_CONTROL, 8'h01 | 8'(p << 4));
            span(d);
            chk("rate", 8'(32 >> p), d);
        end
        $display("test rate done");
    endtask
    task automatic t_ext();
        logic [7:0] d;
        ext_on <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_STATUS, m > 1 ? 8'h04 : 8'h00);
            wr(OFS_CONTROL, m == 1 ? 8'h07 : m == 3 ? 8'h01 : 8'h03);
            span(d);
            chk("ext", m == 2 ? 8'd16 : m == 3 ? 8'd32 : 8'd8, d);
            if (m > 1) chk("pdir", 8'h03, {6'h00, pdir});
            if (m > 1) chk("pread", 8'h00, {6'h00, pread});
        end
        wr(OFS_STATUS, 8'h00);
        chk("pread", 8'h02, {6'h00, pread});
        chk("pdir", 8'h01, {6'h00, pdir});
        ext_on <= 1'b0;
        $display("test ext done");
    endtask
    task automatic t_wide();
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_COUNT_HIGH, 8'h12);
        wr(OFS_COUNT_LOW, 8'h34);
        wr(OFS_COUNT_HIGH, 8'h56);
        rdchk("buf", OFS_COUNT_HIGH, 8'h56);
        rdchk("low", OFS_COUNT_LOW, 8'h34);
        rdchk("latch", OFS_COUNT_HIGH, 8'h12);
        wr(OFS_CONTROL, 8'h00);
        rdchk("live", OFS_COUNT_HIGH, 8'h12);
        $display("test wide done");
    endtask
    task automatic t_ovf();
        wr(OFS_COUNT_HIGH, 8'hFF);
        wr(OFS_COUNT_LOW, 8'hFF);
        wr(OFS_CONTROL, 8'h01);
        repeat (8) @(posedge ref_clk);
        wr(OFS_CONTROL, 8'h00);
        rdchk("flag", OFS_STATUS, 8'h01);
        rdchk("wrap", OFS_COUNT_HIGH, 8'h00);
        chk("irq", 8'h00, {7'h00, irq});
        wr(OFS_STATUS, 8'h02);
        chk("irq", 8'h01, {7'h00, irq});
        wr(OFS_STATUS, 8'h03);
        chk("irq", 8'h00, {7'h00, irq});
        $display("test overflow done");
    endtask
    task automatic t_pre();
        wr(OFS_CONTROL, 8'h30);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h31);
        repeat (4) @(posedge ref_clk);
        wr(OFS_COUNT_HIGH, 8'h00);
        repeat (7) @(posedge ref_clk);
        rdchk("keep", OFS_COUNT_LOW, 8'h01);
        wr(OFS_CONTROL, 8'h30);
        wr(OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h31);
        repeat (12) @(posedge ref_clk);
        rdchk("clear", OFS_COUNT_LOW, 8'h00);
        wr(OFS_CONTROL, 8'h00);
        $display("test prescaler done");
    endtask
    task automatic t_trig();
        logic [7:0] c [4] = '{8'h40, 8'h08, 8'h08, 8'h40};
        logic [7:0] e [4] = '{8'h00, 8'h50, 8'h00, 8'h50};
        int a0;
        a0 = adc_seen;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CONTROL, c[k]);
            chk("uses", c[k][6] ? 8'h03 : 8'h01, {6'h00, u1, u2});
            wr(OFS_COUNT_LOW, 8'h50);
            mode <= k == 3 ? 4'hA : MODE_SPECIAL;
            pulse(k[1]);
            rdchk("trig", OFS_COUNT_LOW, e[k]);
        end
        mode <= MODE_SPECIAL;
        adc_en <= 1'b0;
        fork
            wr(OFS_COUNT_LOW, 8'h77);
            pulse(1'b0);
        join
        rdchk("coincide", OFS_COUNT_LOW, 8'h77);
        rdchk("noflag", OFS_STATUS, 8'h02);
        chk("adc", 8'd2, 8'(adc_seen - a0));
        $display("test trigger done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {arst_n, ext_on, fire1, fire2, fail_count, check_count} = '0;
        mode = 4'h0;
        adc_en = 1'b1;
        req = '0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_rate();
        t_ext();
        t_wide();
        t_ovf();
        t_pre();
        t_trig();
        summarize();
    end
endmodule // testbench
`default_nettype wire
